// ---- common/pas_pkg.sv ----
package pas_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 25_000_000;
    localparam int SLEEP_UNIT_MS     = 100;
    localparam int SLEEP_TICK_CYCLES = CLK_HZ / 1000 * SLEEP_UNIT_MS;
    localparam int INTEG_SHIFT       = 16;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_CFG        = 4'h0;
    localparam logic [3:0] REG_RANGE      = 4'h1;
    localparam logic [3:0] REG_SLEEP_LVL  = 4'h2;
    localparam logic [3:0] REG_SLEEP_TIME = 4'h3;
    localparam logic [3:0] REG_OD_LVL     = 4'h4;
    localparam logic [3:0] REG_FB_OFF     = 4'h5;
    localparam logic [3:0] REG_FB_ON      = 4'h6;
    localparam logic [3:0] REG_IRQ_STS    = 4'h7;
    localparam logic [3:0] REG_IRQ_CLR    = 4'h8;
    localparam logic [3:0] REG_IRQ_EN     = 4'h9;
    localparam logic [3:0] REG_STATE      = 4'ha;
    localparam logic [3:0] REG_LOOP_OUT   = 4'hb;

    // ------------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  FF_SRC_AI1    = 2'h1;
    localparam logic [1:0]  FF_SRC_AI2    = 2'h2;
    localparam logic [4:0]  CFG_RST       = 5'h00;
    localparam logic [15:0] LVL_RST       = 16'h0000;
    localparam logic [15:0] FREQ_MAX      = 16'hffff;
    localparam int          EV_OD         = 0;
    localparam int          EV_FBV        = 1;
    localparam int          EV_SLEEP      = 2;
    localparam int          NUM_EV        = 3;

    // Configuration word, bit 4 down to bit 0 of the configuration register.
    typedef struct packed {
        logic       tgt_src;
        logic       stop_free;
        logic       invert;
        logic [1:0] ff_sel;
    } pas_cfg_s;

    // Multi-function input terminals.
    typedef struct packed {
        logic run;
        logic bypass;
        logic iclr;
    } pas_term_s;

    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'b00,
        SLP_TIMING = 2'b01,
        SLP_ASLEEP = 2'b11
    } pas_slp_e;

endpackage : pas_pkg

// ---- hdl/pas_sync.sv ----
module pas_sync (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // Terminals
    input  wire pas_pkg::pas_term_s pin_raw,
    output pas_pkg::pas_term_s      pin_clean
);

    pas_pkg::pas_term_s s1_q;
    pas_pkg::pas_term_s s2_q;
    pas_pkg::pas_term_s s3_q;
    pas_pkg::pas_term_s clean_q;
    pas_pkg::pas_term_s clean_d;

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    // A bit changes only once the second and third stages agree.
    always_comb begin
        clean_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & clean_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end else begin
            s1_q    <= pin_raw;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            clean_q <= clean_d;
        end
    end

    assign pin_clean = clean_q;

endmodule : pas_sync

// ---- hdl/pas_top.sv ----
// Register access over Avalon-MM and the register offsets are this design's own decisions.
module pas_top #(
    parameter int TICK_CYCLES = pas_pkg::SLEEP_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Process inputs
    input  wire logic [15:0] analog_input_one,
    input  wire logic [15:0] analog_input_two,
    input  wire logic [15:0] freq_cmd,
    // Terminals
    input  wire logic        run_pin,
    input  wire logic        bypass_pin,
    input  wire logic        integrator_clear_input,
    // Drive command
    output logic      [15:0] freq_out,
    output logic             drive_stop,
    output logic             drive_free_run,
    output logic             over_deviation_output,
    output logic             feedback_window_output,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] sat16(input logic signed [19:0] x);
        if (x < 20'sd0) begin
            return 16'h0000;
        end else if (x > $signed({4'h0, pas_pkg::FREQ_MAX})) begin
            return pas_pkg::FREQ_MAX;
        end else begin
            return x[15:0];
        end
    endfunction : sat16

    function automatic logic [15:0] be16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : be16

    // ------------------------------------------------------------------
    // Terminal synchroniser
    // ------------------------------------------------------------------
    pas_pkg::pas_term_s term_raw;
    pas_pkg::pas_term_s term;

    assign term_raw = '{run: run_pin, bypass: bypass_pin,
                        iclr: integrator_clear_input};

    pas_sync u_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_raw   (term_raw),
        .pin_clean (term)
    );

    // ------------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------------
    pas_pkg::pas_cfg_s        cfg_q, cfg_d;
    logic [15:0]              range_q, range_d, slvl_q, slvl_d;
    logic [15:0]              stime_q, stime_d, odlvl_q, odlvl_d;
    logic [15:0]              fboff_q, fboff_d, fbon_q, fbon_d;
    logic [pas_pkg::NUM_EV-1:0] sts_q, sts_d, en_q, en_d, ev;
    logic [31:0]              rdata_q, rdata_d;
    logic                     wait_q, wait_d, irq_q, irq_d;
    logic                     wr_go;
    logic [15:0]              loop_out;
    logic                     od_q, fbv_q, stop_q;

    assign wr_go = avs_write & ~wait_q;

    always_comb begin
        cfg_d   = cfg_q;
        range_d = range_q;
        slvl_d  = slvl_q;
        stime_d = stime_q;
        odlvl_d = odlvl_q;
        fboff_d = fboff_q;
        fbon_d  = fbon_q;
        en_d    = en_q;
        sts_d   = sts_q;
        wait_d  = ~(wait_q & (avs_read | avs_write));
        rdata_d = rdata_q;
        if (wr_go) begin
            if (avs_address == pas_pkg::REG_CFG) begin
                if (avs_byteenable[0]) begin
                    cfg_d = avs_writedata[4:0];
                end
            end else if (avs_address == pas_pkg::REG_RANGE) begin
                range_d = be16(range_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_SLEEP_LVL) begin
                slvl_d = be16(slvl_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_SLEEP_TIME) begin
                stime_d = be16(stime_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_OD_LVL) begin
                odlvl_d = be16(odlvl_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_FB_OFF) begin
                fboff_d = be16(fboff_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_FB_ON) begin
                fbon_d = be16(fbon_q, avs_writedata, avs_byteenable);
            end else if (avs_address == pas_pkg::REG_IRQ_CLR) begin
                if (avs_byteenable[0]) begin
                    sts_d = sts_q & ~avs_writedata[pas_pkg::NUM_EV-1:0];
                end
            end else if (avs_address == pas_pkg::REG_IRQ_EN) begin
                if (avs_byteenable[0]) begin
                    en_d = avs_writedata[pas_pkg::NUM_EV-1:0];
                end
            end
        end
        // A new event wins over a clear in the same cycle.
        sts_d = sts_d | ev;
        irq_d = |(sts_q & en_q);
        if (avs_read & wait_q) begin
            if (avs_address == pas_pkg::REG_CFG) begin
                rdata_d = {27'h0, cfg_q};
            end else if (avs_address == pas_pkg::REG_RANGE) begin
                rdata_d = {16'h0, range_q};
            end else if (avs_address == pas_pkg::REG_SLEEP_LVL) begin
                rdata_d = {16'h0, slvl_q};
            end else if (avs_address == pas_pkg::REG_SLEEP_TIME) begin
                rdata_d = {16'h0, stime_q};
            end else if (avs_address == pas_pkg::REG_OD_LVL) begin
                rdata_d = {16'h0, odlvl_q};
            end else if (avs_address == pas_pkg::REG_FB_OFF) begin
                rdata_d = {16'h0, fboff_q};
            end else if (avs_address == pas_pkg::REG_FB_ON) begin
                rdata_d = {16'h0, fbon_q};
            end else if (avs_address == pas_pkg::REG_IRQ_STS) begin
                rdata_d = {29'h0, sts_q};
            end else if (avs_address == pas_pkg::REG_IRQ_EN) begin
                rdata_d = {29'h0, en_q};
            end else if (avs_address == pas_pkg::REG_STATE) begin
                rdata_d = {26'h0, term.iclr, term.bypass, term.run,
                           stop_q, fbv_q, od_q};
            end else if (avs_address == pas_pkg::REG_LOOP_OUT) begin
                rdata_d = {16'h0, loop_out};
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q   <= pas_pkg::CFG_RST;
            range_q <= pas_pkg::LVL_RST;
            slvl_q  <= pas_pkg::LVL_RST;
            stime_q <= pas_pkg::LVL_RST;
            odlvl_q <= pas_pkg::LVL_RST;
            fboff_q <= pas_pkg::LVL_RST;
            fbon_q  <= pas_pkg::LVL_RST;
            sts_q   <= '0;
            en_q    <= '0;
            rdata_q <= 32'h0000_0000;
            wait_q  <= 1'b1;
            irq_q   <= 1'b0;
        end else begin
            cfg_q   <= cfg_d;
            range_q <= range_d;
            slvl_q  <= slvl_d;
            stime_q <= stime_d;
            odlvl_q <= odlvl_d;
            fboff_q <= fboff_d;
            fbon_q  <= fbon_d;
            sts_q   <= sts_d;
            en_q    <= en_d;
            rdata_q <= rdata_d;
            wait_q  <= wait_d;
            irq_q   <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Loop arithmetic
    // ------------------------------------------------------------------
    // Each analog input is sampled once, every use reads that sample.
    logic [15:0]        ai1_q, ai2_q, target, fb, ff_val;
    logic signed [17:0] dev_raw, dev;
    logic [16:0]        dev_mag;
    logic signed [31:0] integ_q, integ_d, integ_sum;
    logic signed [19:0] loop_pre, lim_lo, lim_hi, loop_lim;
    logic [15:0]        freq_q, freq_d;

    always_comb begin
        target  = cfg_q.tgt_src ? ai2_q : ai1_q;
        fb      = cfg_q.tgt_src ? ai1_q : ai2_q;
        if (cfg_q.ff_sel == pas_pkg::FF_SRC_AI1) begin
            ff_val = ai1_q;
        end else if (cfg_q.ff_sel == pas_pkg::FF_SRC_AI2) begin
            ff_val = ai2_q;
        end else begin
            ff_val = 16'h0000;
        end
        dev_raw = $signed({2'b00, target}) - $signed({2'b00, fb});
        dev     = cfg_q.invert ? -dev_raw : dev_raw;
        dev_mag = dev[17] ? 17'(-dev) : dev[16:0];
        loop_pre = $signed({4'h0, target}) + $signed({4'h0, ff_val})
                 + 20'(dev) + 20'($signed(integ_q[31:pas_pkg::INTEG_SHIFT]));
        lim_lo  = $signed({4'h0, target}) - $signed({4'h0, range_q});
        lim_hi  = $signed({4'h0, target}) + $signed({4'h0, range_q});
        loop_lim = loop_pre;
        if (range_q != 16'h0000) begin
            if (loop_pre > lim_hi) begin
                loop_lim = lim_hi;
            end else if (loop_pre < lim_lo) begin
                loop_lim = lim_lo;
            end
        end
        loop_out  = sat16(loop_lim);
        integ_sum = integ_q + 32'(dev);
        integ_d   = integ_q;
        if (term.iclr || !term.run) begin
            integ_d = 32'sd0;
        end else if (!term.bypass && (integ_sum[31] == integ_q[31]
                     || dev[17] != integ_q[31])) begin
            integ_d = integ_sum;
        end
        if (!term.run) begin
            freq_d = 16'h0000;
        end else if (term.bypass) begin
            freq_d = freq_cmd;
        end else begin
            freq_d = loop_out;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ai1_q   <= 16'h0000;
            ai2_q   <= 16'h0000;
            integ_q <= 32'sd0;
            freq_q  <= 16'h0000;
        end else begin
            ai1_q   <= analog_input_one;
            ai2_q   <= analog_input_two;
            integ_q <= integ_d;
            freq_q  <= freq_d;
        end
    end

    // ------------------------------------------------------------------
    // Sleep timer and status outputs
    // ------------------------------------------------------------------
    pas_pkg::pas_slp_e slp_q, slp_d;
    logic [21:0]       tick_q, tick_d;
    logic [15:0]       scnt_q, scnt_d;
    logic              od_d, fbv_d, stop_d, free_q, free_d;
    logic [15:0]       off_eff;
    logic              low;

    always_comb begin
        slp_d  = slp_q;
        tick_d = tick_q;
        scnt_d = scnt_q;
        // Sleep is judged on the loop output even under bypass.
        low    = loop_out <= slvl_q;
        case (slp_q)
            pas_pkg::SLP_AWAKE: begin
                tick_d = 22'h0;
                scnt_d = 16'h0;
                if (term.run && low) begin
                    slp_d = pas_pkg::SLP_TIMING;
                end
            end
            pas_pkg::SLP_TIMING: begin
                if (!term.run || !low) begin
                    slp_d = pas_pkg::SLP_AWAKE;
                end else if (scnt_q >= stime_q) begin
                    slp_d = pas_pkg::SLP_ASLEEP;
                end else if (tick_q == 22'(TICK_CYCLES - 1)) begin
                    tick_d = 22'h0;
                    scnt_d = scnt_q + 16'h1;
                end else begin
                    tick_d = tick_q + 22'h1;
                end
            end
            pas_pkg::SLP_ASLEEP: begin
                if (!term.run) begin
                    slp_d = pas_pkg::SLP_AWAKE;
                end
            end
            default: begin
                slp_d = pas_pkg::SLP_AWAKE;
            end
        endcase
        stop_d = slp_d == pas_pkg::SLP_ASLEEP;
        free_d = stop_d & cfg_q.stop_free;
        od_d   = dev_mag > {1'b0, odlvl_q};
        off_eff = (fboff_q < fbon_q) ? fbon_q : fboff_q;
        fbv_d  = fbv_q;
        if (!term.run || fbon_q == 16'h0 || fboff_q == 16'h0) begin
            fbv_d = 1'b0;
        end else if (fb < fbon_q) begin
            fbv_d = 1'b1;
        end else if (fb > off_eff) begin
            fbv_d = 1'b0;
        end
        ev = '0;
        ev[pas_pkg::EV_OD]    = od_d & ~od_q;
        ev[pas_pkg::EV_FBV]   = fbv_d & ~fbv_q;
        ev[pas_pkg::EV_SLEEP] = stop_d & ~stop_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slp_q  <= pas_pkg::SLP_AWAKE;
            tick_q <= 22'h0;
            scnt_q <= 16'h0;
            stop_q <= 1'b0;
            free_q <= 1'b0;
            od_q   <= 1'b0;
            fbv_q  <= 1'b0;
        end else begin
            slp_q  <= slp_d;
            tick_q <= tick_d;
            scnt_q <= scnt_d;
            stop_q <= stop_d;
            free_q <= free_d;
            od_q   <= od_d;
            fbv_q  <= fbv_d;
        end
    end

    assign avs_readdata           = rdata_q;
    assign avs_waitrequest        = wait_q;
    assign freq_out               = freq_q;
    assign drive_stop             = stop_q;
    assign drive_free_run         = free_q;
    assign over_deviation_output  = od_q;
    assign feedback_window_output = fbv_q;
    assign irq                    = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ff_inactive: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_q.ff_sel != pas_pkg::FF_SRC_AI1
        && cfg_q.ff_sel != pas_pkg::FF_SRC_AI2 |-> ff_val == 16'h0000)
        else $error("feed-forward active for an unused source code");
    a_ff_shared: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_q.ff_sel == pas_pkg::FF_SRC_AI1 && !cfg_q.tgt_src
        |-> ff_val == target)
        else $error("shared input gave two different values");
    a_dev_invert: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_q.invert |-> dev == $signed({2'b00, fb}) - $signed({2'b00, target}))
        else $error("deviation sign not inverted");
    a_clamp_high: assert property (@(posedge clk_sys) disable iff (rst)
        range_q != 16'h0 && term.run && !term.bypass
        |=> $signed({4'h0, freq_out}) <= $past(lim_hi))
        else $error("loop output above target plus range");
    a_clamp_off: assert property (@(posedge clk_sys) disable iff (rst)
        range_q == 16'h0 |-> loop_lim == loop_pre)
        else $error("clamp applied with zero range");
    a_bypass_cmd: assert property (@(posedge clk_sys) disable iff (rst)
        term.run && term.bypass |=> freq_out == $past(freq_cmd))
        else $error("bypass did not pass the frequency command");
    a_integ_clear: assert property (@(posedge clk_sys) disable iff (rst)
        term.iclr |=> integ_q == 32'sd0)
        else $error("integral term not cleared");
    a_sleep_stop: assert property (@(posedge clk_sys) disable iff (rst)
        slp_q == pas_pkg::SLP_TIMING && term.run && low && scnt_q >= stime_q
        |=> drive_stop && drive_free_run == $past(cfg_q.stop_free))
        else $error("sleep time elapsed without stop");
    a_sleep_bypass: assert property (@(posedge clk_sys) disable iff (rst)
        slp_q == pas_pkg::SLP_AWAKE && term.run && term.bypass && low
        |=> slp_q == pas_pkg::SLP_TIMING)
        else $error("sleep timing not started under bypass");
    a_od_level: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 over_deviation_output == ($past(dev_mag) > {1'b0, $past(odlvl_q)}))
        else $error("over-deviation output wrong");
    a_fbv_below: assert property (@(posedge clk_sys) disable iff (rst)
        term.run && fbon_q != 16'h0 && fboff_q != 16'h0 && fb < fbon_q
        |=> feedback_window_output)
        else $error("window output off below on level");
    a_fbv_swap: assert property (@(posedge clk_sys) disable iff (rst)
        term.run && fbon_q != 16'h0 && fboff_q != 16'h0 && fboff_q < fbon_q
        && fb > fbon_q |=> !feedback_window_output)
        else $error("off level not replaced by on level");
    a_fbv_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !term.run || fbon_q == 16'h0 || fboff_q == 16'h0
        |=> !feedback_window_output)
        else $error("window output on while inactive");
    a_fbv_hold: assert property (@(posedge clk_sys) disable iff (rst)
        term.run && fbon_q != 16'h0 && fboff_q != 16'h0 && fb >= fbon_q
        && fb <= off_eff |=> $stable(feedback_window_output))
        else $error("window output moved between levels");

endmodule : pas_top

// ---- verification/pas_proc_model.sv ----
module pas_proc_model (
    // Settings from the bench
    input  wire logic [15:0] tgt,
    input  wire logic [15:0] fb,
    // Analog inputs of the block
    output logic      [15:0] analog_input_one,
    output logic      [15:0] analog_input_two
);
    timeunit 1ns;
    timeprecision 1ps;
    // Target on the first input, feedback on the second.
    assign analog_input_one = tgt;
    assign analog_input_two = fb;
endmodule : pas_proc_model

// ---- verification/pid_aux_supervision_bench.sv ----
module pid_aux_supervision_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, rd_q = 0, wr_q = 0, run = 0, byp = 0;
    logic iclr = 0;
    logic [3:0] adr = 0;
    logic [31:0] wd = 0, rdat, v;
    logic [15:0] a1, a2, tgt = 0, fb = 0, cmd = 0, fo;
    logic wq, stp, frn, od, fbw, irq;
    int mismatches = 0, n_tests = 0, cyc = 0;
    always #20 clk_sys = ~clk_sys;
    pas_proc_model u_mdl (.tgt(tgt), .fb(fb), .analog_input_one(a1),
        .analog_input_two(a2));
    pas_top #(.TICK_CYCLES(4)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(adr), .avs_read(rd_q), .avs_write(wr_q),
        .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdat),
        .avs_waitrequest(wq), .analog_input_one(a1),
        .analog_input_two(a2), .freq_cmd(cmd), .run_pin(run),
        .bypass_pin(byp), .integrator_clear_input(iclr), .freq_out(fo),
        .drive_stop(stp), .drive_free_run(frn),
        .over_deviation_output(od), .feedback_window_output(fbw),
        .irq(irq));
    task automatic chk(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [15:0] d);
        adr <= a;
        wd <= {16'h0000, d};
        if (w) wr_q <= 1'b1; else rd_q <= 1'b1;
        do @(posedge clk_sys); while (wq !== 1'b0);
        v = rdat;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge clk_sys);
    endtask : acc
    task automatic settle(input logic [15:0] f);
        fb <= f;
        repeat (8) @(posedge clk_sys);
    endtask : settle
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        acc(0, pas_pkg::REG_IRQ_STS, 0);
        chk("sts_rst", v, 0);
        acc(0, 4'hf, 0);
        chk("unmapped", v, 0);
        acc(1, pas_pkg::REG_FB_ON, 100);
        acc(1, pas_pkg::REG_FB_OFF, 50);
        acc(1, pas_pkg::REG_OD_LVL, 10);
        acc(1, pas_pkg::REG_IRQ_EN, 7);
        tgt <= 1000;
        run <= 1'b1;
        settle(1000);
        chk("od_low", od, 0);
        settle(75);
        chk("od_high", od, 1);
        chk("fbv_on", fbw, 1);
        chk("irq_on", irq, 1);
        settle(150);
        chk("fbv_off", fbw, 0);
        acc(1, pas_pkg::REG_FB_OFF, 200);
        settle(10);
        settle(150);
        chk("fbv_hold1", fbw, 1);
        settle(300);
        settle(150);
        chk("fbv_hold0", fbw, 0);
        acc(1, pas_pkg::REG_FB_OFF, 0);
        settle(10);
        chk("fbv_zero", fbw, 0);
        acc(1, pas_pkg::REG_FB_OFF, 200);
        acc(1, pas_pkg::REG_RANGE, 5);
        settle(10);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("clamp_hi", v, 1005);
        acc(1, pas_pkg::REG_CFG, 5'h04);
        settle(10);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("clamp_lo", v, 995);
        settle(1000);
        acc(1, pas_pkg::REG_IRQ_CLR, 7);
        repeat (3) @(posedge clk_sys);
        chk("irq_clr", irq, 0);
        acc(1, pas_pkg::REG_CFG, 5'h00);
        acc(1, pas_pkg::REG_RANGE, 0);
        tgt <= 16'd30000;
        settle(0);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("clamp_off", v > 30005, 1);
        settle(16'd30000);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("integ_held", v > 30000, 1);
        byp <= 1'b1;
        settle(16'd30000);
        iclr <= 1'b1;
        settle(16'd30000);
        iclr <= 1'b0;
        byp <= 1'b0;
        settle(16'd30000);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("integ_clr", v, 30000);
        acc(1, pas_pkg::REG_CFG, 5'h02);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("ff_ai2", v, 60000);
        acc(1, pas_pkg::REG_CFG, 5'h03);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("ff_off", v, 30000);
        acc(1, pas_pkg::REG_CFG, 5'h11);
        acc(0, pas_pkg::REG_LOOP_OUT, 0);
        chk("ff_shared", v, 60000);
        acc(1, pas_pkg::REG_CFG, 5'h00);
        settle(10);
        run <= 1'b0;
        settle(10);
        chk("fbv_stop", fbw, 0);
        cmd <= 16'h1234;
        byp <= 1'b1;
        run <= 1'b1;
        settle(10);
        chk("bypass", fo, 16'h1234);
        acc(1, pas_pkg::REG_CFG, 5'h08);
        acc(1, pas_pkg::REG_SLEEP_TIME, 1);
        acc(1, pas_pkg::REG_SLEEP_LVL, 16'hffff);
        repeat (20) @(posedge clk_sys);
        chk("sleep", {stp, frn}, 2'b11);
        conclude();
    end
endmodule : pid_aux_supervision_bench
